// ---- dv/host_serial_model.sv ----
// host serial master model driving select, clock and data pins
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
   // serial pins
   output logic chip_select_n,
   output logic serial_clock_in,
   output logic serial_data_in,
   input wire logic serial_data_out
);
   initial begin
      chip_select_n = 1'b1;
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
   end
   // n rising edges per frame, read bit taken at each rise
   task automatic frame(input logic [15:0] w, input int n,
         output logic [15:0] r);
      r = 16'h0000;
      chip_select_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         serial_data_in = w[15-i];
         #80 serial_clock_in = 1'b1;
         r[15-i] = serial_data_out;
         #80 serial_clock_in = 1'b0;
      end
      #80 chip_select_n = 1'b1;
      // released line shows the inverse of its last value
      serial_data_in = ~serial_data_in;
      #160;
   endtask
endmodule
`default_nettype wire

// ---- dv/touch_serial_gpio_properties.sv ----
// assertions on the serial port and pin block outputs
`timescale 1ns/10ps
`default_nettype none
module touch_serial_gpio_properties (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial select
   input wire logic chip_select_n,
   // pins and status
   input wire logic [3:0] io_pin_out,
   input wire logic [3:0] io_pin_oe,
   input wire logic [2:0] aux_analog_sel,
   input wire logic alert_n,
   input wire logic [11:0] setup_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_analog_no_drive:
      assert property ((aux_analog_sel & io_pin_oe[2:0]) == 3'h0)
      else $error("analog pin driven");
   a_setup_quiet:
      assert property (chip_select_n[*8] |=> $stable(setup_reg))
      else $error("setup moved while deselected");
   a_sel_quiet:
      assert property (chip_select_n[*8] |=> $stable(aux_analog_sel))
      else $error("analog select moved while deselected");
   a_oe_quiet:
      assert property (chip_select_n[*8] |=> $stable(io_pin_oe))
      else $error("pin enables moved while deselected");
   a_drive_quiet:
      assert property (chip_select_n[*8] |=> $stable(io_pin_out & io_pin_oe))
      else $error("driven level moved while deselected");
   a_alert_outputs:
      assert property ((&io_pin_oe)[*5] |=> alert_n)
      else $error("alert with all pins driving");
   a_alert_cause:
      assert property ($fell(alert_n) |-> $past(io_pin_oe) != 4'hF)
      else $error("alert fell with no input pin");
   a_ptr_step:
      assert property ($changed(setup_reg) && (setup_reg & 12'h83F) ==
         ($past(setup_reg) & 12'h83F) |-> setup_reg[10:6] ==
         $past(setup_reg[10:6]) + 5'h01)
      else $error("pointer step wrong");
endmodule
bind touch_serial_gpio touch_serial_gpio_properties chk (.clk, .resetn,
   .chip_select_n, .io_pin_out, .io_pin_oe, .aux_analog_sel, .alert_n,
   .setup_reg);
`default_nettype wire

// ---- dv/touch_serial_gpio_tb.sv ----
// testbench for the serial port and pin block
`timescale 1ns/10ps
`default_nettype none
module touch_serial_gpio_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] io_pin_in = 4'h0;
   logic cs_n, sclk, sdi, sdo, alert_n;
   logic [3:0] pin_out, pin_oe;
   logic [2:0] aux_sel;
   logic [11:0] setup;
   logic [15:0] rd;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   touch_serial_gpio DUT (.clk(clk), .resetn(resetn),
      .chip_select_n(cs_n), .serial_clock_in(sclk),
      .serial_data_in(sdi), .serial_data_out(sdo),
      .io_pin_in(io_pin_in), .io_pin_out(pin_out), .io_pin_oe(pin_oe),
      .aux_analog_sel(aux_sel), .alert_n(alert_n), .setup_reg(setup));
   host_serial_model host (.chip_select_n(cs_n), .serial_clock_in(sclk),
      .serial_data_in(sdi), .serial_data_out(sdo));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic t_readback;
      host.frame(16'h1055, 16, rd);
      host.frame(16'h0000, 16, rd);
      check(rd, 16'h0055, "setup read");
      check(setup, 12'h095, "ptr step");
      $display("readback done");
   endtask
   task automatic t_short;
      host.frame(16'h1FFF, 12, rd);
      check(setup, 12'h095, "short word");
      $display("short done");
   endtask
   task automatic t_pins;
      io_pin_in = 4'h2;
      host.frame(16'hF0FA, 16, rd);
      host.frame(16'hF201, 16, rd);
      #200;
      check(pin_oe, 4'h9, "enables");
      check(pin_out & pin_oe, 4'h9, "levels");
      check(aux_sel, 3'h4, "analog sel");
      check(alert_n, 1'b0, "alert on");
      host.frame(16'h16EA, 16, rd);
      host.frame(16'h0000, 16, rd);
      check(rd, 16'h00FA, "cfg a");
      host.frame(16'h0000, 16, rd);
      check(rd, 16'h0000, "cfg b");
      // this frame reads pointer 1Dh before its own write commits
      host.frame(16'hF200, 16, rd);
      check(rd, 16'h0003, "level before");
      // point back at the level data to see the written value
      host.frame(16'h1740, 16, rd);
      host.frame(16'h0000, 16, rd);
      check(rd, 16'h0002, "level data");
      io_pin_in = 4'h0;
      host.frame(16'hF0F8, 16, rd);
      #200;
      check(alert_n, 1'b1, "alert off");
      check(pin_out[0], 1'b1, "inverted");
      io_pin_in = 4'h2;
      #200;
      check(alert_n, 1'b0, "alert again");
      host.frame(16'hF0E8, 16, rd);
      check(alert_n, 1'b1, "alert masked");
      host.frame(16'hF088, 16, rd);
      host.frame(16'hF188, 16, rd);
      check(pin_oe, 4'hF, "all out");
      $display("pins done");
   endtask
   task automatic t_wrap;
      host.frame(16'h17D5, 16, rd);
      host.frame(16'h0000, 16, rd);
      check(setup, 12'h015, "wrap");
      $display("wrap done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_readback();
      t_short();
      t_pins();
      t_wrap();
      conclude();
   end
endmodule
`default_nettype wire

// ---- rtl/touch_serial_gpio.sv ----
// serial register port and general-purpose pin logic of the touch controller
// What this block does
// [RULE1] write word is 4 address bits then 12 payload bits
// [RULE2] address 0000b writes are discarded with no effect
// [RULE3] addresses 0010b to 1110b load their own 12-bit register
// [RULE4] address 1111b writes low eight bits to extended pin register
// [RULE5] address 0001b loads setup register holding the 5-bit read pointer
// [RULE6] host should write the setup register last before conversion
// [RULE7] chip select high: clock and data ignored, no transfers
// [RULE8] write is 16 clocks, input sampled on rising serial clock
// [RULE9] host raises chip select between write words
// [RULE10] read msb driven at select fall, later bits on clock fall
// [RULE11] read returns pointed register, then pointer increments
// [RULE12] next read continues from pointer unless setup rewritten
// [RULE13] pointer at 11111b is reset to zero after its read
// [RULE14] readback pads 12-bit regs with 4 zeros, pin regs with 8
// [RULE15] pin regs at extended 0,1,2 and read pointer 1Bh to 1Dh
// [RULE16] claim bit 0 makes shared pin analog; dedicated pin always logic
// [RULE17] drive_sense 0: pin outputs data bit through level_sense
// [RULE18] drive_sense 1: data follows pin, host writes ignored
// [RULE19] level_sense 1: pin and data bit non-inverted
// [RULE20] level_sense 0: pin and data bit inverted
// [RULE21] only pins with pin_irq_gate set may assert alert
// [RULE22] alert low when gated input pin has data bit set
// [RULE23] alert releases when every source is removed or ungated
// [RULE24] a word cut short by chip select rising is dropped
`timescale 1ns/10ps
`default_nettype none
module touch_serial_gpio
   import touch_serial_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial port pins
   input wire logic chip_select_n,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   // pins 0..2 shared with aux inputs, pin 3 is dedicated_io_pin
   input wire logic [3:0] io_pin_in,
   output logic [3:0] io_pin_out,
   output logic [3:0] io_pin_oe,
   output logic [2:0] aux_analog_sel,
   // alert, active low
   output logic alert_n,
   // setup register contents for the converter side
   output logic [11:0] setup_reg
);
   typedef logic [11:0] phys_t [16];

   typedef struct packed {
      logic [1:0] cs_sync;
      logic [1:0] sck_sync;
      logic [1:0] din_sync;
      logic [3:0][1:0] pin_sync;
      logic sck_prev;
      logic cs_prev;
      logic [4:0] bit_cnt;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic read_done;
      logic [11:0] setup;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] level_data;
      logic dout;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic [2:0] aux_sel;
      logic alert_n;
   } state_t;

   state_t s_q, s_d;
   phys_t phys_q;
   logic phys_we;
   logic [3:0] phys_addr;
   logic [11:0] phys_data;

   function automatic logic [3:0] pin_cfg(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input int idx);
      logic [15:0] all;
      all = {b, a};
      return all[idx*4 +: 4];
   endfunction

   // level_sense 1 passes the level through, 0 inverts it
   function automatic logic apply_sense(input logic sense,
                                        input logic v);
      return sense ? v : !v;
   endfunction

   function automatic logic [15:0] read_word(input logic [4:0] ptr,
                                             input state_t s,
                                             input phys_t p);
      logic [15:0] w;
      w = 16'h0000;
      if (ptr == RADDR_CONFIG_A) begin
         w = {8'h00, s.cfg_a}; // RULE14
      end else if (ptr == RADDR_CONFIG_B) begin
         w = {8'h00, s.cfg_b}; // RULE15
      end else if (ptr == RADDR_LEVEL_DATA) begin
         w = {8'h00, s.level_data}; // RULE15
      end else if (ptr == 5'({1'b0, WADDR_SETUP})) begin
         w = {4'h0, s.setup}; // RULE14
      end else if (ptr[4] == 1'b0) begin
         w = {4'h0, p[ptr[3:0]]}; // RULE14
      end
      return w;
   endfunction

   logic [4:0] rptr;
   assign rptr = s_q.setup[RPTR_LSB +: RPTR_BITS];

   always_comb begin
      logic sck_rise;
      logic sck_fall;
      logic cs_fall;
      logic cs_rise;
      logic active;
      logic [15:0] word;
      logic [3:0] cfg;
      logic [4:0] nptr;
      logic alert_any;
      logic pin_lvl;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      active = 1'b0;
      word = 16'h0000;
      cfg = 4'h0;
      nptr = 5'h00;
      alert_any = 1'b0;
      pin_lvl = 1'b0;
      s_d = s_q;
      phys_we = 1'b0;
      phys_addr = 4'h0;
      phys_data = 12'h000;

      s_d.cs_sync = {s_q.cs_sync[0], chip_select_n};
      s_d.sck_sync = {s_q.sck_sync[0], serial_clock_in};
      s_d.din_sync = {s_q.din_sync[0], serial_data_in};
      for (int i = 0; i < PIN_COUNT; i++) begin
         s_d.pin_sync[i] = {s_q.pin_sync[i][0], io_pin_in[i]};
      end
      s_d.sck_prev = s_q.sck_sync[1];
      s_d.cs_prev = s_q.cs_sync[1];
      active = !s_q.cs_sync[1]; // RULE7
      sck_rise = active && s_q.sck_sync[1] && !s_q.sck_prev;
      sck_fall = active && !s_q.sck_sync[1] && s_q.sck_prev;
      cs_fall = s_q.cs_prev && !s_q.cs_sync[1];
      cs_rise = !s_q.cs_prev && s_q.cs_sync[1];

      if (cs_fall) begin
         // load the pointed word; msb appears at once
         word = read_word(rptr, s_q, phys_q); // RULE11
         s_d.shift_out = {word[14:0], 1'b0};
         s_d.dout = word[15]; // RULE10
         s_d.bit_cnt = 5'd0;
         s_d.read_done = 1'b0;
      end else if (sck_rise) begin
         s_d.shift_in = {s_q.shift_in[14:0], s_q.din_sync[1]}; // RULE8
         if (s_q.bit_cnt != 5'd16) begin
            s_d.bit_cnt = s_q.bit_cnt + 5'd1;
         end
      end else if (sck_fall && s_q.bit_cnt != 5'd0) begin
         s_d.dout = s_q.shift_out[15]; // RULE10
         s_d.shift_out = {s_q.shift_out[14:0], 1'b0};
      end

      // pointer advances once the 16th bit has gone out
      if (sck_rise && s_q.bit_cnt == 5'd15 && !s_q.read_done) begin
         s_d.read_done = 1'b1;
         nptr = (rptr == RADDR_WRAP) ? 5'h00 : rptr + 5'd1; // RULE13
         s_d.setup[RPTR_LSB +: RPTR_BITS] = nptr; // RULE11 RULE12
      end

      // a word commits only at select rise after at least 16 clocks, keeping the last 16 bits
      if (cs_rise && s_q.bit_cnt == 5'd16) begin // RULE24 RULE9
         word = s_q.shift_in; // RULE1
         if (word[15:12] == WADDR_SETUP) begin
            s_d.setup = word[11:0]; // RULE5 RULE12
         end else if (word[15:12] >= WADDR_FIRST_PHYS &&
                      word[15:12] <= WADDR_LAST_PHYS) begin
            phys_we = 1'b1; // RULE3
            phys_addr = word[15:12];
            phys_data = word[11:0];
         end else if (word[15:12] == WADDR_EXTENDED) begin
            if (word[11:8] == XADDR_CONFIG_A) begin
               s_d.cfg_a = word[7:0]; // RULE4
            end else if (word[11:8] == XADDR_CONFIG_B) begin
               s_d.cfg_b = word[7:0]; // RULE4
            end else if (word[11:8] == XADDR_LEVEL_DATA) begin
               for (int i = 0; i < PIN_COUNT; i++) begin
                  cfg = pin_cfg(s_q.cfg_a, s_q.cfg_b, i);
                  if (!cfg[CFG_DRIVE_SENSE]) begin
                     s_d.level_data[i] = word[i]; // RULE18
                  end
               end
            end
         end
         // address 0000b falls through untouched  RULE2
      end
      if (cs_rise) begin
         s_d.bit_cnt = 5'd0;
      end

      for (int i = 0; i < PIN_COUNT; i++) begin
         cfg = pin_cfg(s_q.cfg_a, s_q.cfg_b, i);
         if (i == PIN_COUNT - 1) begin
            cfg[CFG_CLAIM] = 1'b1; // RULE16
         end
         pin_lvl = s_q.pin_sync[i][1];
         if (!cfg[CFG_CLAIM]) begin
            s_d.pin_oe[i] = 1'b0; // RULE16
            s_d.pin_out[i] = 1'b0;
         end else if (cfg[CFG_DRIVE_SENSE]) begin
            s_d.pin_oe[i] = 1'b0;
            s_d.pin_out[i] = 1'b0;
            s_d.level_data[i] = apply_sense(cfg[CFG_LEVEL_SENSE],
                                            pin_lvl); // RULE18 RULE19 RULE20
            if (cfg[CFG_IRQ_GATE] && s_d.level_data[i]) begin
               alert_any = 1'b1; // RULE21 RULE22
            end
         end else begin
            s_d.pin_oe[i] = 1'b1; // RULE17
            s_d.pin_out[i] = apply_sense(cfg[CFG_LEVEL_SENSE],
                                         s_q.level_data[i]); // RULE19 RULE20
         end
         if (i < PIN_COUNT - 1) begin
            s_d.aux_sel[i] = !cfg[CFG_CLAIM]; // RULE16
         end
      end
      s_d.alert_n = !alert_any; // RULE23
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.cs_sync <= 2'b11;
         s_q.cs_prev <= 1'b1;
         s_q.setup <= PHYS_RESET;
         s_q.cfg_a <= PIN_REG_RESET;
         s_q.cfg_b <= PIN_REG_RESET;
         s_q.level_data <= PIN_REG_RESET;
         s_q.aux_sel <= 3'b111;
         s_q.alert_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++) begin
            phys_q[i] <= PHYS_RESET;
         end
      end else if (phys_we) begin
         phys_q[phys_addr] <= phys_data; // RULE3
      end
   end

   assign serial_data_out = s_q.dout;
   assign io_pin_out = s_q.pin_out;
   assign io_pin_oe = s_q.pin_oe;
   assign aux_analog_sel = s_q.aux_sel;
   assign alert_n = s_q.alert_n;
   assign setup_reg = s_q.setup;
endmodule
`default_nettype wire

// ---- rtl/touch_serial_pkg.sv ----
// constants for the touch controller serial port and pin logic
package touch_serial_pkg;
   localparam int WORD_BITS = 16;
   localparam int ADDR_BITS = 4;
   localparam int PAYLOAD_BITS = 12;
   localparam int RPTR_BITS = 5;
   localparam int PIN_COUNT = 4;
   localparam logic [3:0] WADDR_NONE = 4'h0;
   localparam logic [3:0] WADDR_SETUP = 4'h1;
   localparam logic [3:0] WADDR_FIRST_PHYS = 4'h2;
   localparam logic [3:0] WADDR_LAST_PHYS = 4'hE;
   localparam logic [3:0] WADDR_EXTENDED = 4'hF;
   localparam logic [3:0] XADDR_CONFIG_A = 4'h0;
   localparam logic [3:0] XADDR_CONFIG_B = 4'h1;
   localparam logic [3:0] XADDR_LEVEL_DATA = 4'h2;
   localparam logic [4:0] RADDR_CONFIG_A = 5'h1B;
   localparam logic [4:0] RADDR_CONFIG_B = 5'h1C;
   localparam logic [4:0] RADDR_LEVEL_DATA = 5'h1D;
   localparam logic [4:0] RADDR_WRAP = 5'h1F;
   // read pointer field inside the setup register
   localparam int RPTR_LSB = 6;
   // per-pin config nibble: claim, drive_sense, level_sense, pin_irq_gate
   localparam int CFG_CLAIM = 3;
   localparam int CFG_DRIVE_SENSE = 2;
   localparam int CFG_LEVEL_SENSE = 1;
   localparam int CFG_IRQ_GATE = 0;
   localparam logic [11:0] PHYS_RESET = 12'h000;
   localparam logic [7:0] PIN_REG_RESET = 8'h00;
   localparam logic [7:0] DIR_IN_ALL = 8'h44;
endpackage
